/* design/line_port_ctrl.sv */
// Purpose: one channel's mode and signal control registers and steering
// Assumes: all pins synchronous to sys_clk; line clocks sampled as levels
// Notes:   global interface select and status bank live outside
`timescale 1ns/1ps
`include "line_port_params.svh"
module line_port_ctrl #(
  parameter logic [3:0] PORT_ADDR = `PORT_ADDR_DFLT
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Serial register port
  input  wire logic regSelect_b,
  input  wire logic regClk,
  input  wire logic regDataIn,
  output logic      regDataOut,
  output logic      regDataOutEn_b,
  // Global settings and strap
  input  wire logic systemInterfaceSelect,
  input  wire logic clockModeStrap,
  input  wire logic cmiLineMode,
  // Transmit system side
  input  wire logic txSysClk,
  input  wire logic txSysData,
  input  wire logic txParallelClockIn,
  output logic      txParallelClockOut,
  output logic      txParallelClockOutEn_b,
  output logic      txCapturedData,
  // Transmit line side
  input  wire logic txLineData,
  output logic      lineOutP,
  output logic      lineOutN,
  output logic      lineOutEn_b,
  // Receive side
  input  wire logic lineInP,
  input  wire logic rxRecoveredData,
  input  wire logic rxClk,
  input  wire logic rxSysData,
  output logic      rxCoreIn,
  output logic      rxSysDataOut,
  // Alarm detection
  input  wire logic rxLockRaw,
  input  wire logic rxSignalRaw,
  output logic      rxLockLost,
  output logic      rxSignalLost,
  // Path and analog controls
  output logic      txPowerDown,
  output logic      rxPowerDown,
  output logic      rxMonitorGain,
  output logic      cruEnable,
  output logic      fifoEnable,
  output logic      loopTiming,
  output logic      fifoPointerReset,
  // FIFO error
  input  wire logic fifoErrEvent,
  output logic      fifoPhaseError
);
  logic                    txPd_ff;
  logic                    rxPd_ff;
  logic                    pclkSrc_ff;
  line_port_pkg::tx_path_t serPath_ff;
  logic                    mon_ff;
  logic [7:0]              sig_ff;
  logic                    strapPend_ff;
  logic [3:0]              cmdPort;
  logic [2:0]              cmdSub;
  logic                    cmdRead;
  logic [7:0]              wrData;
  logic                    wrStrobe;
  logic [7:0]              rdData;
  logic                    rdHit;
  logic                    wrMode;
  logic                    wrSig;
  logic                    parallel;
  logic                    master;
  logic [3:0]              divCnt_ff;
  logic                    txClkGen_ff;
  logic                    txClkLvl;
  logic                    txClkQ_ff;
  logic                    rxClkQ_ff;
  logic                    txEdge;
  logic                    rxEdge;
  logic [7:0]              losCnt_ff;
  logic [7:0]              lolCnt_ff;
  logic                    override;

  function automatic logic hits(input logic [3:0] port,
                                input logic [2:0] sub,
                                input logic [2:0] ofs);
    hits = (port == PORT_ADDR) && (sub == ofs);
  endfunction

  function automatic logic [7:0] satInc(input logic [7:0] cnt,
                                        input logic [7:0] lim);
    satInc = (cnt == lim) ? cnt : cnt + 8'h01;
  endfunction

  serial_reg_port u_port (
    .sys_clk        (sys_clk),
    .rst_b          (rst_b),
    .regSelect_b    (regSelect_b),
    .regClk         (regClk),
    .regDataIn      (regDataIn),
    .regDataOut     (regDataOut),
    .regDataOutEn_b (regDataOutEn_b),
    .cmdPort        (cmdPort),
    .cmdSub         (cmdSub),
    .cmdRead        (cmdRead),
    .wrData         (wrData),
    .wrStrobe       (wrStrobe),
    .rdData         (rdData),
    .rdHit          (rdHit)
  );

  assign parallel = systemInterfaceSelect;
  assign master = parallel & pclkSrc_ff;
  assign override = sig_ff[`SIG_OVERRIDE];
  assign wrMode = wrStrobe & ~cmdRead & hits(cmdPort, cmdSub, `REG_MODE_OFS);
  assign wrSig = wrStrobe & ~cmdRead & hits(cmdPort, cmdSub, `REG_SIG_OFS);

  // Register bank; strap values land on the first edge after release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txPd_ff <= 1'b0;
      rxPd_ff <= 1'b0;
      pclkSrc_ff <= 1'b0;
      serPath_ff <= line_port_pkg::PATH_FIFO;
      mon_ff <= 1'b0;
      strapPend_ff <= 1'b1;
    end else if (strapPend_ff) begin
      strapPend_ff <= 1'b0;
      pclkSrc_ff <= clockModeStrap;
      serPath_ff <= clockModeStrap ? line_port_pkg::PATH_PLESIO
                                   : line_port_pkg::PATH_FIFO;
    end else if (wrMode) begin
      txPd_ff <= wrData[`MODE_TX_PD];
      rxPd_ff <= wrData[`MODE_RX_PD];
      pclkSrc_ff <= wrData[`MODE_PCLK];
      serPath_ff <= line_port_pkg::tx_path_t'(
                      wrData[`MODE_PATH_HI:`MODE_PATH_LO]);
      mon_ff <= wrData[`MODE_MON];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sig_ff <= `SIG_RST;
    end else if (wrSig) begin
      sig_ff <= wrData;
    end
  end

  // Read side; only this port's two offsets answer
  always_comb begin
    rdHit = hits(cmdPort, cmdSub, `REG_MODE_OFS) |
            hits(cmdPort, cmdSub, `REG_SIG_OFS);
    if (cmdSub == `REG_MODE_OFS) begin
      rdData = {txPd_ff, rxPd_ff, pclkSrc_ff | ~parallel,
                serPath_ff, mon_ff, `MODE_RSVD_RD};
    end else begin
      rdData = sig_ff;
    end
  end

  // Transmit clock: framer clock in or divided internal clock out
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_ff <= 4'h0;
      txClkGen_ff <= 1'b0;
    end else if (!master) begin
      divCnt_ff <= 4'h0;
      txClkGen_ff <= 1'b0;
    end else if (divCnt_ff == `TXCLK_HALF) begin
      divCnt_ff <= 4'h0;
      txClkGen_ff <= ~txClkGen_ff;
    end else begin
      divCnt_ff <= divCnt_ff + 4'h1;
    end
  end

  assign txParallelClockOut = txClkGen_ff;
  assign txParallelClockOutEn_b = ~master;
  assign txClkLvl = master ? txClkGen_ff
                  : (parallel ? txParallelClockIn : txSysClk);
  assign txEdge = sig_ff[`SIG_TCLK_INV] ? (txClkQ_ff & ~txClkLvl)
                                        : (~txClkQ_ff & txClkLvl);
  assign rxEdge = sig_ff[`SIG_RCLK_INV] ? (~rxClkQ_ff & rxClk)
                                        : (rxClkQ_ff & ~rxClk);

  // Capture and launch on the selected edges
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txClkQ_ff <= 1'b0;
      rxClkQ_ff <= 1'b0;
      txCapturedData <= 1'b0;
      rxSysDataOut <= 1'b0;
    end else begin
      txClkQ_ff <= txClkLvl;
      rxClkQ_ff <= rxClk;
      if (txEdge) begin
        txCapturedData <= txSysData;
      end
      if (rxEdge) begin
        rxSysDataOut <= rxSysData;
      end
    end
  end

  // Line side steering: loopbacks, polarity, power-down
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineOutP <= 1'b0;
      lineOutN <= 1'b0;
      lineOutEn_b <= 1'b1;
      rxCoreIn <= 1'b0;
      rxMonitorGain <= 1'b0;
    end else begin
      lineOutEn_b <= txPd_ff;
      if (txPd_ff) begin
        lineOutP <= 1'b0;
        lineOutN <= 1'b0;
      end else if (sig_ff[`SIG_REMOTE_LOOPBACK] && !sig_ff[`SIG_LOCAL_LOOPBACK]) begin
        lineOutP <= rxRecoveredData ^ sig_ff[`SIG_TX_FLIP];
        lineOutN <= ~(rxRecoveredData ^ sig_ff[`SIG_TX_FLIP]);
      end else begin
        lineOutP <= txLineData ^ sig_ff[`SIG_TX_FLIP];
        lineOutN <= ~(txLineData ^ sig_ff[`SIG_TX_FLIP]);
      end
      if (rxPd_ff) begin
        rxCoreIn <= 1'b0;
      end else if (sig_ff[`SIG_LOCAL_LOOPBACK]) begin
        rxCoreIn <= txLineData;
      end else begin
        rxCoreIn <= lineInP ^ sig_ff[`SIG_RX_FLIP];
      end
      // Gain stage has no meaning on the NRZ optical path
      rxMonitorGain <= mon_ff & cmiLineMode & ~rxPd_ff;
    end
  end

  assign txPowerDown = txPd_ff;
  assign rxPowerDown = rxPd_ff;

  // Serial routing; parallel mode always runs through the FIFO
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cruEnable <= 1'b0;
      fifoEnable <= 1'b1;
      loopTiming <= 1'b0;
    end else if (parallel) begin
      cruEnable <= 1'b0;
      fifoEnable <= 1'b1;
      loopTiming <= 1'b0;
    end else begin
      case (serPath_ff)
        line_port_pkg::PATH_FIFO: begin
          cruEnable <= 1'b0;
          fifoEnable <= 1'b1;
          loopTiming <= 1'b0;
        end
        line_port_pkg::PATH_CRU_FIFO: begin
          cruEnable <= 1'b1;
          fifoEnable <= 1'b1;
          loopTiming <= 1'b0;
        end
        line_port_pkg::PATH_PLESIO: begin
          cruEnable <= 1'b1;
          fifoEnable <= 1'b0;
          loopTiming <= 1'b0;
        end
        line_port_pkg::PATH_LOOP: begin
          cruEnable <= 1'b0;
          fifoEnable <= 1'b1;
          loopTiming <= 1'b1;
        end
        default: begin
          cruEnable <= 1'b0;
          fifoEnable <= 1'b1;
          loopTiming <= 1'b0;
        end
      endcase
    end
  end

  // Loss detectors; override keeps them quiet and counters cleared
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      losCnt_ff <= 8'h00;
      lolCnt_ff <= 8'h00;
      rxSignalLost <= 1'b0;
      rxLockLost <= 1'b0;
    end else if (override) begin
      losCnt_ff <= 8'h00;
      lolCnt_ff <= 8'h00;
      rxSignalLost <= 1'b0;
      rxLockLost <= 1'b0;
    end else begin
      losCnt_ff <= rxSignalRaw ? satInc(losCnt_ff, `LOS_LIMIT) : 8'h00;
      lolCnt_ff <= rxLockRaw ? satInc(lolCnt_ff, `LOL_LIMIT) : 8'h00;
      rxSignalLost <= losCnt_ff == `LOS_LIMIT;
      rxLockLost <= lolCnt_ff == `LOL_LIMIT;
    end
  end

  // FIFO reset is a level held while the bit is one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fifoPointerReset <= 1'b0;
      fifoPhaseError <= 1'b0;
    end else begin
      fifoPointerReset <= sig_ff[`SIG_FIFO_RST];
      if (sig_ff[`SIG_FIFO_RST]) begin
        fifoPhaseError <= 1'b0;
      end else if (fifoErrEvent) begin
        fifoPhaseError <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence fifoResetWritten;
    (wrSig && wrData[`SIG_FIFO_RST]) ##1 1'b1;
  endsequence

  a_tx_pd_float: assert property (txPd_ff |=> lineOutEn_b && !lineOutP)
    else $error("line pair driven while powered down");
  a_pclk_serial_read: assert property (
    (!parallel && rdHit && cmdSub == `REG_MODE_OFS) |-> rdData[5])
    else $error("clock source bit not one in serial mode");
  a_strap_default: assert property (
    strapPend_ff |=> pclkSrc_ff == $past(clockModeStrap))
    else $error("strap default not loaded");
  a_plesio_bypass: assert property (
    (!parallel && serPath_ff == line_port_pkg::PATH_PLESIO)
      |=> cruEnable && !fifoEnable)
    else $error("plesiochronous path not bypassing FIFO");
  a_override_quiet: assert property (
    override [*2] |-> !rxSignalLost && !rxLockLost && losCnt_ff == 8'h00)
    else $error("alarm raised under override");
  a_local_loop: assert property (
    (sig_ff[`SIG_LOCAL_LOOPBACK] && !rxPd_ff) |=> rxCoreIn == $past(txLineData))
    else $error("local loopback not feeding receiver");
  a_rx_launch_edge: assert property (
    (!sig_ff[`SIG_RCLK_INV] && rxClkQ_ff && !rxClk)
      |=> rxSysDataOut == $past(rxSysData))
    else $error("receive data not launched on falling edge");
  a_fifo_err_clear: assert property (
    fifoResetWritten |=> !fifoPhaseError && fifoPointerReset)
    else $error("FIFO reset did not clear phase error");
  a_mon_gain_cmi: assert property (
    rxMonitorGain |-> $past(cmiLineMode) && $past(mon_ff))
    else $error("monitor gain outside CMI mode");
endmodule

/* design/line_port_params.svh */
// Purpose: constants for the per-port mode and signal control bank
// Assumes: one channel per instance, 8-bit registers
// Notes:   included by bare name; definitions only
// How it works
// - Transmit power-down stops the transmitter and floats the line output pair.
// - Receive power-down bit: 0 runs the receiver, 1 powers it down; resets 0.
// - Serial interface selected: parallel clock source ignored and reads as one.
// - Parallel mode: source 0 takes framer clock in, 1 drives internal clock out.
// - Clock source and serial path bits load from the clock mode strap at reset.
// - Serial path 00: clock and data through FIFO, clock recovery bypassed.
// - Serial path 10: data through clock recovery, then through the FIFO.
// - Serial path 01: clock recovered from data, FIFO bypassed.
// - Monitor bit adds flat receive gain, only while the line uses CMI coding.
// - Transmit polarity bit inverts the transmit line output data.
// - Receive polarity bit inverts incoming line data before processing.
// - Alarm override holds lock and signal loss low, detection counters reset.
// - Remote loopback alone returns recovered receive data to the driver.
// - Local loopback feeds transmit data into the receiver input.
// - Receive clock invert: 0 launches on falling edge, 1 on rising edge.
// - Transmit clock invert: 0 captures on rising edge, 1 on falling edge.
// - FIFO reset bit returns transmit FIFO pointers to centred positions.
// - Interface select: 0 serial, 1 parallel; mode fields depend on it.
// - FIFO reset also clears the transmit FIFO phase error flag.
`ifndef LINE_PORT_PARAMS_SVH
`define LINE_PORT_PARAMS_SVH
`define REG_MODE_OFS    3'h0
`define REG_SIG_OFS     3'h1
`define PORT_ADDR_DFLT  4'h1
`define MODE_TX_PD      7
`define MODE_RX_PD      6
`define MODE_PCLK       5
`define MODE_MON        2
`define MODE_PATH_HI    4
`define MODE_PATH_LO    3
`define MODE_RSVD_RD    2'h0
`define SIG_TX_FLIP     7
`define SIG_RX_FLIP     6
`define SIG_OVERRIDE    5
`define SIG_REMOTE_LOOPBACK        4
`define SIG_LOCAL_LOOPBACK        3
`define SIG_RCLK_INV    2
`define SIG_TCLK_INV    1
`define SIG_FIFO_RST    0
`define SIG_RST         8'h00
`define CMD_LAST_BIT    5'h07
`define FRAME_LAST_BIT  5'h0f
`define LOS_LIMIT       8'h20
`define LOL_LIMIT       8'h40
`define TXCLK_HALF      4'h3
`endif

/* design/line_port_pkg.sv */
// Purpose: shared types for the line port control bank
// Assumes: constants live in line_port_params.svh
// Notes:   one-hot state codes written out
package line_port_pkg;
  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_CMD  = 3'b010,
    SP_DATA = 3'b100
  } serial_state_t;

  typedef enum logic [1:0] {
    PATH_FIFO     = 2'b00,
    PATH_PLESIO   = 2'b01,
    PATH_CRU_FIFO = 2'b10,
    PATH_LOOP     = 2'b11
  } tx_path_t;
endpackage

/* design/serial_reg_port.sv */
// Purpose: serial register port slave: command byte then data byte
// Assumes: pins synchronous to sys_clk, port clock much slower
// Notes:   MSB first; device samples on rise, shifts out on fall
`timescale 1ns/1ps
`include "line_port_params.svh"
module serial_reg_port (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Port pins
  input  wire logic       regSelect_b,
  input  wire logic       regClk,
  input  wire logic       regDataIn,
  output logic            regDataOut,
  output logic            regDataOutEn_b,
  // Decoded access
  output logic [3:0]      cmdPort,
  output logic [2:0]      cmdSub,
  output logic            cmdRead,
  output logic [7:0]      wrData,
  output logic            wrStrobe,
  input  wire logic [7:0] rdData,
  input  wire logic       rdHit
);
  line_port_pkg::serial_state_t state_ff;
  logic       regClkQ_ff;
  logic [4:0] bitCnt_ff;
  logic [7:0] shiftIn_ff;
  logic [7:0] cmd_ff;
  logic [7:0] shiftOut_ff;
  logic       drive_ff;
  logic       fetch_ff;
  logic       rise;
  logic       fall;

  assign rise = regClk & ~regClkQ_ff;
  assign fall = ~regClk & regClkQ_ff;
  assign cmdRead = cmd_ff[7];
  assign cmdPort = cmd_ff[6:3];
  assign cmdSub = cmd_ff[2:0];
  assign regDataOut = shiftOut_ff[7];
  assign regDataOutEn_b = ~drive_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regClkQ_ff <= 1'b0;
    end else begin
      regClkQ_ff <= regClk;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= line_port_pkg::SP_IDLE;
      bitCnt_ff <= 5'h00;
    end else if (regSelect_b) begin
      state_ff <= line_port_pkg::SP_IDLE;
      bitCnt_ff <= 5'h00;
    end else begin
      if (rise && state_ff != line_port_pkg::SP_IDLE) begin
        bitCnt_ff <= bitCnt_ff + 5'h01;
      end
      case (state_ff)
        line_port_pkg::SP_IDLE: begin
          // A finished frame leaves the count nonzero until deselect
          if (bitCnt_ff == 5'h00) begin
            state_ff <= line_port_pkg::SP_CMD;
          end
        end
        line_port_pkg::SP_CMD: begin
          if (rise && bitCnt_ff == `CMD_LAST_BIT) begin
            state_ff <= line_port_pkg::SP_DATA;
          end
        end
        line_port_pkg::SP_DATA: begin
          if (rise && bitCnt_ff == `FRAME_LAST_BIT) begin
            state_ff <= line_port_pkg::SP_IDLE;
          end
        end
        default: state_ff <= line_port_pkg::SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftIn_ff <= 8'h00;
      cmd_ff <= 8'h00;
      fetch_ff <= 1'b0;
      wrStrobe <= 1'b0;
      wrData <= 8'h00;
    end else begin
      fetch_ff <= 1'b0;
      wrStrobe <= 1'b0;
      if (rise && !regSelect_b) begin
        shiftIn_ff <= {shiftIn_ff[6:0], regDataIn};
        if (state_ff == line_port_pkg::SP_CMD &&
            bitCnt_ff == `CMD_LAST_BIT) begin
          cmd_ff <= {shiftIn_ff[6:0], regDataIn};
          fetch_ff <= shiftIn_ff[6];
        end
        if (state_ff == line_port_pkg::SP_DATA &&
            bitCnt_ff == `FRAME_LAST_BIT && !cmd_ff[7]) begin
          wrData <= {shiftIn_ff[6:0], regDataIn};
          wrStrobe <= 1'b1;
        end
      end
    end
  end

  // Unmatched port addresses never drive the data pin
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftOut_ff <= 8'h00;
      drive_ff <= 1'b0;
    end else if (regSelect_b) begin
      drive_ff <= 1'b0;
    end else if (fetch_ff) begin
      shiftOut_ff <= rdData;
      drive_ff <= rdHit;
    end else if (fall && bitCnt_ff > `CMD_LAST_BIT + 5'h01) begin
      shiftOut_ff <= {shiftOut_ff[6:0], 1'b0};
    end
  end
endmodule

/* test/framer_model.sv */
// Purpose: framer model driving the transmit system side of one port
// Assumes: transmit clock spans ten sys_clk periods
// Notes:   data changes twice a period, midway between clock edges,
//          so a capture on the wrong edge sees the other value
`timescale 1ns/1ps
module framer_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Capture edge in use at the device
  input  wire logic captureFalling,
  // Transmit system side
  output logic      txSysClk,
  output logic      txSysData,
  output logic      txParallelClockIn,
  output logic      settled
);
  logic [3:0] phase_ff;

  assign txSysClk          = (phase_ff < 4'h5);
  assign txParallelClockIn = txSysClk;
  // Last cycle before the next launch: the capture must have landed
  assign settled = (phase_ff == (captureFalling ? 4'h7 : 4'h2));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_ff <= 4'h0;
    end else begin
      phase_ff <= (phase_ff == 4'h9) ? 4'h0 : phase_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txSysData <= 1'b0;
    end else if (phase_ff == 4'h2 || phase_ff == 4'h7) begin
      txSysData <= ~txSysData;
    end
  end
endmodule

/* test/line_port_mode_signal_control_bench.sv */
// Purpose: self-checking bench for the port mode and signal registers
// Assumes: port address 1, strap high, serial interface at start
// Notes:   each regClk phase lasts four sys_clk
`timescale 1ns/1ps
module line_port_mode_signal_control_bench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic regSelect_b = 1'b1;
  logic regClk = 1'b0;
  logic regDataIn = 1'b0;
  logic systemInterfaceSelect = 1'b0;
  logic clockModeStrap = 1'b1;
  logic cmiLineMode = 1'b1;
  logic txLineData = 1'b0;
  logic lineInP = 1'b0;
  logic rxRecoveredData = 1'b0;
  logic fifoErrEvent = 1'b0;
  logic rxClk = 1'b0;
  logic rxSysData = 1'b0;
  logic rxLockRaw = 1'b0;
  logic rxSignalRaw = 1'b0;
  logic [7:0] sigShadow = 8'h00;
  logic regDataOut, regDataOutEn_b, txSysClk, txSysData, txParallelClockIn;
  logic txParallelClockOut, txParallelClockOutEn_b, txCapturedData;
  logic lineOutP, lineOutN, lineOutEn_b, rxCoreIn, rxLockLost, rxSignalLost;
  logic txPowerDown, rxPowerDown, rxMonitorGain, cruEnable, fifoEnable;
  logic loopTiming, fifoPointerReset, fifoPhaseError, settled, rxSysDataOut;
  int   failures = 0;
  int   checked = 0;

  always #5 sys_clk = ~sys_clk;

  line_port_ctrl #(.PORT_ADDR(4'h1)) line_port_ctrl_i (
    .sys_clk, .rst_b, .regSelect_b, .regClk, .regDataIn, .regDataOut,
    .regDataOutEn_b, .systemInterfaceSelect, .clockModeStrap, .cmiLineMode,
    .txSysClk, .txSysData, .txParallelClockIn, .txParallelClockOut,
    .txParallelClockOutEn_b, .txCapturedData, .txLineData, .lineOutP,
    .lineOutN, .lineOutEn_b, .lineInP, .rxRecoveredData, .rxClk,
    .rxSysData, .rxCoreIn, .rxSysDataOut, .rxLockRaw, .rxSignalRaw,
    .rxLockLost, .rxSignalLost, .txPowerDown, .rxPowerDown, .rxMonitorGain,
    .cruEnable, .fifoEnable, .loopTiming, .fifoPointerReset, .fifoErrEvent,
    .fifoPhaseError);

  framer_model framer_model_i (
    .sys_clk, .rst_b, .captureFalling(sigShadow[1]), .txSysClk, .txSysData,
    .txParallelClockIn, .settled);

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Outputs are judged half a cycle after the edge, once updates landed
  task automatic settle(input int n);
    cyc(n);
    @(negedge sys_clk);
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic frame(input logic [7:0] cmd, input logic [7:0] din,
                       output logic [7:0] dout);
    logic [15:0] bits;
    bits = {cmd, din};
    dout = 8'h00;
    @(posedge sys_clk) regSelect_b <= 1'b0;
    for (int k = 15; k >= 0; k--) begin
      @(posedge sys_clk) regDataIn <= bits[k];
      regClk <= 1'b0;
      cyc(3);
      @(posedge sys_clk) regClk <= 1'b1;
      settle(3);
      // A released data pin floats; a refused read must show that
      if (k < 8) dout[k] = regDataOutEn_b ? 1'bz : regDataOut;
    end
    @(posedge sys_clk) regClk <= 1'b0;
    cyc(3);
    @(posedge sys_clk) regSelect_b <= 1'b1;
    cyc(2);
  endtask

  task automatic wr(input logic [3:0] port, input logic [2:0] sub,
                    input logic [7:0] val);
    logic [7:0] unused;
    frame({1'b0, port, sub}, val, unused);
  endtask

  task automatic mode(input logic [7:0] v);
    wr(4'h1, 3'h0, v);
  endtask

  task automatic sig(input logic [7:0] v);
    sigShadow <= v;
    wr(4'h1, 3'h1, v);
  endtask

  task automatic rd(input logic [2:0] sub, input logic [7:0] exp);
    logic [7:0] got;
    frame({1'b1, 4'h1, sub}, 8'h00, got);
    chk("register read", exp, got);
  endtask

  task automatic t_reset();
    rd(3'h0, 8'h28);
    rd(3'h1, 8'h00);
    settle(0);
    chk("path flags", 8'h04, {5'h0, cruEnable, fifoEnable, loopTiming});
    $display("test reset done");
  endtask

  task automatic t_paths();
    logic [1:0] code [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
    logic [2:0] want [4] = '{3'b010, 3'b110, 3'b100, 3'b011};
    for (int i = 0; i < 4; i++) begin
      mode({3'b000, code[i], 3'b000});
      settle(1);
      chk("path flags", {5'h0, want[i]}, {5'h0, cruEnable, fifoEnable, loopTiming});
      rd(3'h0, {3'b001, code[i], 3'b000});
    end
    $display("test paths done");
  endtask

  task automatic t_clock_source();
    logic first;
    @(posedge sys_clk) systemInterfaceSelect <= 1'b1;
    mode(8'h00);
    rd(3'h0, 8'h00);
    chk("clock out enable", 8'h01, {7'h0, txParallelClockOutEn_b});
    mode(8'h20);
    settle(1);
    first = txParallelClockOut;
    chk("clock out enable", 8'h00, {7'h0, txParallelClockOutEn_b});
    settle(3);
    chk("clock out toggle", {7'h0, ~first}, {7'h0, txParallelClockOut});
    @(posedge sys_clk) systemInterfaceSelect <= 1'b0;
    mode(8'h00);
    rd(3'h0, 8'h20);
    chk("clock out enable", 8'h01, {7'h0, txParallelClockOutEn_b});
    $display("test clock source done");
  endtask

  task automatic t_power();
    mode(8'hc4);
    settle(1);
    chk("power down", 8'h26, {2'h0, lineOutEn_b, lineOutP, lineOutN, txPowerDown, rxPowerDown, rxMonitorGain});
    mode(8'h04);
    settle(1);
    chk("monitor gain", 8'h01, {5'h0, lineOutEn_b, rxPowerDown, rxMonitorGain});
    @(posedge sys_clk) cmiLineMode <= 1'b0;
    settle(2);
    chk("monitor gain", 8'h00, {7'h0, rxMonitorGain});
    @(posedge sys_clk) cmiLineMode <= 1'b1;
    mode(8'h00);
    $display("test power done");
  endtask

  task automatic t_line();
    @(posedge sys_clk) txLineData <= 1'b1;
    lineInP <= 1'b1;
    settle(2);
    chk("line normal", 8'h05, {5'h0, lineOutP, lineOutN, rxCoreIn});
    sig(8'hc0);
    settle(1);
    chk("line flipped", 8'h02, {5'h0, lineOutP, lineOutN, rxCoreIn});
    sig(8'h08);
    @(posedge sys_clk) lineInP <= 1'b0;
    settle(2);
    chk("local loopback", 8'h01, {7'h0, rxCoreIn});
    sig(8'h10);
    @(posedge sys_clk) txLineData <= 1'b0;
    rxRecoveredData <= 1'b1;
    settle(2);
    chk("remote loopback", 8'h01, {7'h0, lineOutP});
    sig(8'h00);
    settle(1);
    chk("loopback off", 8'h00, {7'h0, lineOutP});
    $display("test line done");
  endtask

  task automatic t_alarm();
    @(posedge sys_clk) rxLockRaw <= 1'b1;
    rxSignalRaw <= 1'b1;
    settle(70);
    chk("alarms raised", 8'h03, {6'h0, rxLockLost, rxSignalLost});
    sig(8'h20);
    chk("alarms held low", 8'h00, {6'h0, rxLockLost, rxSignalLost});
    sig(8'h00);
    settle(10);
    chk("counters restarted", 8'h00, {6'h0, rxLockLost, rxSignalLost});
    settle(60);
    chk("alarms raised", 8'h03, {6'h0, rxLockLost, rxSignalLost});
    @(posedge sys_clk) rxLockRaw <= 1'b0;
    rxSignalRaw <= 1'b0;
    $display("test alarm done");
  endtask

  task automatic t_fifo();
    @(posedge sys_clk) fifoErrEvent <= 1'b1;
    @(posedge sys_clk) fifoErrEvent <= 1'b0;
    settle(2);
    chk("phase error", 8'h01, {7'h0, fifoPhaseError});
    sig(8'h01);
    @(posedge sys_clk) fifoErrEvent <= 1'b1;
    @(posedge sys_clk) fifoErrEvent <= 1'b0;
    settle(2);
    chk("fifo reset", 8'h02, {6'h0, fifoPointerReset, fifoPhaseError});
    sig(8'h00);
    chk("fifo reset off", 8'h00, {6'h0, fifoPointerReset, fifoPhaseError});
    $display("test fifo done");
  endtask

  task automatic t_refuse_and_edges();
    logic [7:0] got;
    wr(4'h2, 3'h0, 8'hc0);
    wr(4'h1, 3'h3, 8'hc0);
    rd(3'h0, 8'h20);
    frame({1'b1, 4'h2, 3'h0}, 8'h00, got);
    chk("refused read", 8'hzz, got);
    for (int inv = 0; inv < 2; inv++) begin
      sig({5'h0, inv[0], inv[0], 1'b0});
      settle(20);
      repeat (40) begin
        @(negedge sys_clk);
        if (settled) chk("tx capture", {7'h0, txSysData}, {7'h0, txCapturedData});
      end
      @(posedge sys_clk) rxClk <= 1'b1;
      rxSysData <= ~inv[0];
      settle(3);
      chk("rx launch", 8'h00, {7'h0, rxSysDataOut});
      @(posedge sys_clk) rxClk <= 1'b0;
      rxSysData <= 1'b1;
      settle(3);
      chk("rx launch", {7'h0, ~inv[0]}, {7'h0, rxSysDataOut});
    end
    sig(8'h00);
    $display("test refuse and edges done");
  endtask

  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    cyc(5);
    rst_b <= 1'b1;
    cyc(2);
    t_reset();
    // Start-up toggle so the lock counter begins clean
    sig(8'h20);
    sig(8'h00);
    t_fifo();
    t_paths();
    t_clock_source();
    t_power();
    t_line();
    t_alarm();
    t_refuse_and_edges();
    tally_and_finish();
  end

  // Whole run needs about 5100 cycles
  initial begin
    cyc(50000);
    failures++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
